//--- spi_frame_map.svh
`ifndef SPI_FRAME_MAP_SVH
`define SPI_FRAME_MAP_SVH

// ==========================================================================
// Frame layout
`define ADDR_LAST      4'hf
`define CTRL_LAST      4'h7
`define DATA_LAST      4'h7
`define CTRL_BLK_HI    7
`define CTRL_BLK_LO    3
`define CTRL_RW_BIT    2
`define CTRL_LEN_HI    1
`define CTRL_LEN_LO    0

// ==========================================================================
// Field codes
`define RW_WRITE       1'h1
`define LEN_VARIABLE   2'h0
`define LEN_ONE        2'h1
`define LEN_TWO        2'h2
`define LEN_FOUR       2'h3
`define BYTES_ONE      3'h1
`define BYTES_TWO      3'h2
`define BYTES_FOUR     3'h4
`define BLK_COMMON     5'h00
`define BLK_KIND_REG   2'h1
`define BLK_KIND_TX    2'h2
`define BLK_KIND_RX    2'h3
`define TX_MEM_BYTES   16384
`define RX_MEM_BYTES   16384
`define SOCK_BUF_INIT  2048

`endif

//--- spi_frame_pkg.sv
`default_nettype none
package spi_frame_pkg;

  typedef enum logic [1:0] {ph_addr, ph_ctrl, ph_data} phase_e;

  typedef enum logic [2:0] {
    blk_common, blk_sock_reg, blk_sock_tx, blk_sock_rx, blk_reserved
  } block_kind_e;

  typedef struct packed {
    block_kind_e kind;
    logic [2:0]  socket;
  } block_sel_s;

  typedef struct packed {
    logic        write;
    block_sel_s  blk;
    logic [15:0] offset;
    logic [7:0]  wdata;
  } access_s;

  typedef struct packed {
    logic        sclk_prev;
    phase_e      phase;
    logic [3:0]  bit_cnt;
    logic [15:0] shreg;
    logic [15:0] offset;
    logic [4:0]  blk_field;
    logic        rw;
    logic [1:0]  len;
    logic [2:0]  bytes_left;
    logic [7:0]  txbyte;
    logic        rd_pending;
    logic        miso;
    logic        miso_oe;
    access_s     acc;
    logic        acc_valid;
    logic        frame_done;
    logic        frame_error;
  } port_state_s;

endpackage
`default_nettype wire

//--- pin_sync.sv
`default_nettype none
// ==========================================================================
// Two-stage synchroniser for asynchronous pins
module pin_sync #(
  parameter int W = 3
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;

  sync_s s;
  sync_s next_s;

  always_comb begin
    next_s.meta   = pin_in;
    next_s.stable = s.meta;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pin_sync = s.stable;

endmodule
`default_nettype wire

//--- spi_fixed_length_frame_port.sv
// Operation
// - Variable-length mode ends the data phase when chip select rises.
// - Fixed-length mode takes data length from length codes 01/10/11; code 00 gives one byte and flags an error.
// - Both modes share identical address, control and data phase layout.
// - Write: flag 1, length 01/10/11; host drives data bytes on MOSI.
// - Read: flag 0, length 01/10/11; device returns data bytes on MISO.
// - Frame: 16-bit offset, 5-bit block, flag, 2-bit length, data, MSB first.
// - Block selector picks common, socket register, or socket buffer block.
// - Socket buffers live in shared 16KB TX and RX memories, 2KB each.
// - Buffer blocks accept the full offset range 0x0000 to 0xffff.
// - Variable-length mode uses length 00; data runs while select is low.
// - Successive data bytes go to consecutive offsets from the start offset.
`default_nettype none
`include "spi_frame_map.svh"
module spi_fixed_length_frame_port
  import spi_frame_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       chip_select_n,
  input  wire logic       fixed_length_mode,
  input  wire logic [7:0] rd_data,
  output logic            miso,
  output logic            miso_oe,
  output access_s         acc,
  output logic            acc_valid,
  output logic            frame_done,
  output logic            frame_error
);

  // ========================================================================
  // Pin synchronisation
  logic [2:0] pins;
  logic       sclk_s;
  logic       mosi_s;
  logic       cs_n_s;

  pin_sync #(.W(3)) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin_in   ({sclk, mosi, chip_select_n}),
    .pin_sync (pins)
  );

  assign sclk_s = pins[2];
  assign mosi_s = pins[1];
  assign cs_n_s = pins[0];

  // ========================================================================
  // Helpers
  function automatic block_sel_s decode_block(input logic [4:0] f);
    block_sel_s b;
    b.socket = f[4:2];
    // Buffer blocks map into the shared 16KB memories outside this port
    case (f[1:0])
      `BLK_KIND_REG: b.kind = blk_sock_reg;
      `BLK_KIND_TX:  b.kind = blk_sock_tx;
      `BLK_KIND_RX:  b.kind = blk_sock_rx;
      default:       b.kind = (f == `BLK_COMMON) ? blk_common : blk_reserved;
    endcase
    return b;
  endfunction

  function automatic logic [2:0] len_bytes(input logic [1:0] l);
    case (l)
      `LEN_TWO:  return `BYTES_TWO;
      `LEN_FOUR: return `BYTES_FOUR;
      default:   return `BYTES_ONE;
    endcase
  endfunction

  // ========================================================================
  // Frame engine
  port_state_s s;
  port_state_s next_s;
  logic        rise;
  logic        fall;
  logic [7:0]  ctrl_byte;
  logic        last_byte;

  assign rise = sclk_s & ~s.sclk_prev;
  assign fall = ~sclk_s & s.sclk_prev;
  assign ctrl_byte = {s.shreg[6:0], mosi_s};
  assign last_byte = fixed_length_mode && (s.bytes_left == `BYTES_ONE);

  always_comb begin
    next_s = s;
    next_s.sclk_prev   = sclk_s;
    next_s.acc_valid   = 1'b0;
    next_s.frame_done  = 1'b0;
    next_s.frame_error = 1'b0;
    // Read data arrives the cycle after the strobe
    next_s.rd_pending  = s.acc_valid & ~s.acc.write;
    if (s.rd_pending) begin
      next_s.txbyte = rd_data;
    end
    if (!fixed_length_mode && cs_n_s) begin
      // Select released: abandon whatever phase was under way
      next_s.phase   = ph_addr;
      next_s.bit_cnt = '0;
      next_s.miso_oe = 1'b0;
    end else if (rise) begin
      next_s.shreg   = {s.shreg[14:0], mosi_s};
      next_s.bit_cnt = s.bit_cnt + 4'h1;
      case (s.phase)
        ph_addr: begin
          if (s.bit_cnt == `ADDR_LAST) begin
            next_s.offset  = {s.shreg[14:0], mosi_s};
            next_s.phase   = ph_ctrl;
            next_s.bit_cnt = '0;
          end
        end
        ph_ctrl: begin
          if (s.bit_cnt == `CTRL_LAST) begin
            next_s.blk_field  = ctrl_byte[`CTRL_BLK_HI:`CTRL_BLK_LO];
            next_s.rw         = ctrl_byte[`CTRL_RW_BIT];
            next_s.len        = ctrl_byte[`CTRL_LEN_HI:`CTRL_LEN_LO];
            next_s.bytes_left = len_bytes(next_s.len);
            next_s.phase      = ph_data;
            next_s.bit_cnt    = '0;
            // Fixed mode cannot end on 00; treated as one byte
            next_s.frame_error = fixed_length_mode &&
                                 (next_s.len == `LEN_VARIABLE);
            if (next_s.rw != `RW_WRITE) begin
              // First read is fetched ahead of the first falling edge
              next_s.acc.write  = 1'b0;
              next_s.acc.blk    = decode_block(next_s.blk_field);
              next_s.acc.offset = s.offset;
              next_s.acc_valid  = next_s.acc.blk.kind != blk_reserved;
              next_s.miso_oe    = 1'b1;
            end
          end
        end
        ph_data: begin
          if (s.bit_cnt == `DATA_LAST) begin
            next_s.bit_cnt    = '0;
            next_s.offset     = s.offset + 16'h1;
            next_s.bytes_left = s.bytes_left - 3'h1;
            next_s.acc.blk    = decode_block(s.blk_field);
            if (s.rw == `RW_WRITE) begin
              next_s.acc.write  = 1'b1;
              next_s.acc.offset = s.offset;
              next_s.acc.wdata  = ctrl_byte;
              next_s.acc_valid  = next_s.acc.blk.kind != blk_reserved;
            end else if (!last_byte) begin
              // Variable mode may prefetch one byte past the frame end
              next_s.acc.write  = 1'b0;
              next_s.acc.offset = s.offset + 16'h1;
              next_s.acc_valid  = next_s.acc.blk.kind != blk_reserved;
            end
            if (last_byte) begin
              next_s.phase      = ph_addr;
              next_s.miso_oe    = 1'b0;
              next_s.frame_done = 1'b1;
            end
          end
        end
        default: begin
          next_s.phase   = ph_addr;
          next_s.bit_cnt = '0;
        end
      endcase
    end else if (fall && s.phase == ph_data && s.rw != `RW_WRITE) begin
      next_s.miso   = s.txbyte[7];
      next_s.txbyte = {s.txbyte[6:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign miso        = s.miso;
  assign miso_oe     = s.miso_oe;
  assign acc         = s.acc;
  assign acc_valid   = s.acc_valid;
  assign frame_done  = s.frame_done;
  assign frame_error = s.frame_error;

  // ========================================================================
  // Checks
  logic [2:0]  done_bytes;
  logic [15:0] last_wr_off;
  logic        wr_seen;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      done_bytes  <= '0;
      last_wr_off <= '0;
      wr_seen     <= 1'b0;
    end else begin
      if (s.phase == ph_ctrl) begin
        done_bytes <= '0;
        wr_seen    <= 1'b0;
      end else if (rise && s.phase == ph_data &&
                   s.bit_cnt == `DATA_LAST) begin
        done_bytes <= done_bytes + 3'h1;
      end
      if (s.acc_valid && s.acc.write) begin
        last_wr_off <= s.acc.offset;
        wr_seen     <= 1'b1;
      end
    end
  end

  sequence ctrl_ends;
    rise && s.phase == ph_ctrl && s.bit_cnt == `CTRL_LAST;
  endsequence

  sequence read_ctrl_ends;
    ctrl_ends ##0 (ctrl_byte[`CTRL_RW_BIT] != `RW_WRITE) &&
      (ctrl_byte[`CTRL_BLK_HI:`CTRL_BLK_LO] == `BLK_COMMON ||
       ctrl_byte[`CTRL_BLK_LO+1:`CTRL_BLK_LO] != 2'h0);
  endsequence

  a_cs_release_idle: assert property (@(posedge core_clk) disable iff (!rstn)
    (!fixed_length_mode && cs_n_s) |=> s.phase == ph_addr && !s.miso_oe)
    else $error("select release did not end frame");

  a_fixed_len_count: assert property (@(posedge core_clk) disable iff (!rstn)
    s.frame_done |-> done_bytes == len_bytes(s.len))
    else $error("frame length differs from length code");

  a_restart_addr: assert property (@(posedge core_clk) disable iff (!rstn)
    s.frame_done |-> s.phase == ph_addr && s.bit_cnt == 4'h0)
    else $error("no new address after frame end");

  a_var_open_end: assert property (@(posedge core_clk) disable iff (!rstn)
    !fixed_length_mode |-> !s.frame_done)
    else $error("variable frame ended by length");

  a_read_strobe: assert property (@(posedge core_clk) disable iff (!rstn)
    read_ctrl_ends |=> s.acc_valid && !s.acc.write && s.miso_oe
      ##2 s.txbyte == $past(rd_data))
    else $error("read not fetched after control phase");

  a_write_strobe: assert property (@(posedge core_clk) disable iff (!rstn)
    (rise && s.phase == ph_data && s.bit_cnt == `DATA_LAST &&
     s.rw == `RW_WRITE && s.blk_field == `BLK_COMMON)
      |=> s.acc_valid && s.acc.write && s.acc.wdata == $past(ctrl_byte))
    else $error("write byte not delivered");

  a_write_offsets: assert property (@(posedge core_clk) disable iff (!rstn)
    (s.acc_valid && s.acc.write && wr_seen && s.phase == ph_data)
      |-> s.acc.offset == last_wr_off + 16'h1)
    else $error("write offsets not consecutive");

  a_block_decode: assert property (@(posedge core_clk) disable iff (!rstn)
    s.acc_valid |-> (s.acc.blk.kind == blk_sock_tx) ==
      (s.blk_field[1:0] == `BLK_KIND_TX) && s.acc.blk.socket == s.blk_field[4:2])
    else $error("block selector mis-decoded");

  a_addr_to_ctrl: assert property (@(posedge core_clk) disable iff (!rstn)
    (s.phase == ph_addr && rise && s.bit_cnt == `ADDR_LAST &&
     !(cs_n_s && !fixed_length_mode))
      |=> s.phase == ph_ctrl && s.offset == $past({s.shreg[14:0], mosi_s}))
    else $error("address phase not 16 bits");

  a_miso_in_read: assert property (@(posedge core_clk) disable iff (!rstn)
    s.miso_oe |-> s.phase == ph_data && s.rw != `RW_WRITE)
    else $error("MISO driven outside read data");

endmodule
`default_nettype wire

//--- spi_host_model.sv
`default_nettype none
// ==========================================================================
// Serial bus master standing in for the host processor
module spi_host_model (
  output logic      sclk,
  output logic      mosi,
  output logic      chip_select_n,
  input  wire logic miso_line
);
  timeunit 1ns;
  timeprecision 100ps;

  // Mode 0: clock idles low and stands still between frames
  initial begin
    sclk          = 1'h0;
    mosi          = 1'h0;
    chip_select_n = 1'h0;
  end

  task automatic xfer(input logic var_mode, input logic [15:0] off,
                      input logic [7:0] ctrl, input int nbytes,
                      input logic [31:0] wd, output logic [31:0] rd);
    logic [63:0] bits;
    bits = {off, ctrl, wd, wd[31:24]};
    rd = 32'h0;
    chip_select_n = 1'h0;
    // Odd lead-in sets the serial edges at a fixed phase away from the core clock edges
    #43.7;
    for (int i = 0; i < 24 + 8 * nbytes; i++) begin
      mosi = bits[63 - i];
      #40 sclk = 1'h1;
      if (i >= 24) rd = {rd[30:0], miso_line};
      #40 sclk = 1'h0;
    end
    // A released line shows the inverse, never the stale bit
    mosi = ~mosi;
    #40;
    if (var_mode) chip_select_n = 1'h1;
  endtask
endmodule
`default_nettype wire

//--- spi_fixed_length_frame_port_tb.sv
`default_nettype none
module spi_fixed_length_frame_port_tb
  import spi_frame_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic        fm;
    logic        rw;
    logic [1:0]  len;
    logic [4:0]  bsb;
    logic [15:0] off;
    logic [31:0] wd;
    logic [2:0]  n;
    block_kind_e kind;
    logic [2:0]  sock;
  } row_s;

  logic        core_clk = 1'h0;
  logic        rstn = 1'h0;
  logic        fixed_length_mode = 1'h1;
  logic        sclk, mosi, chip_select_n, miso, miso_oe, miso_line;
  logic [7:0]  rd_data;
  access_s     acc;
  logic        acc_valid, frame_done, frame_error;
  access_s     acc_q[$];
  int          fails = 0, check_count = 0, dones = 0, errs = 0;

  // ==========================================================================
  // Environment
  always #5 core_clk = ~core_clk;

  // The store answers with a byte derived from the offset
  assign rd_data   = acc.offset[7:0] ^ 8'h5a;
  assign miso_line = miso_oe ? miso : ~miso;

  spi_fixed_length_frame_port u_dut (.core_clk(core_clk), .rstn(rstn),
    .sclk(sclk), .mosi(mosi), .chip_select_n(chip_select_n),
    .fixed_length_mode(fixed_length_mode), .rd_data(rd_data),
    .miso(miso), .miso_oe(miso_oe), .acc(acc), .acc_valid(acc_valid),
    .frame_done(frame_done), .frame_error(frame_error));

  spi_host_model u_host (.sclk(sclk), .mosi(mosi),
    .chip_select_n(chip_select_n), .miso_line(miso_line));

  // Strobes are taken mid-cycle so the edge that launches them is settled
  always @(negedge core_clk) begin
    if (acc_valid === 1'h1) acc_q.push_back(acc);
    if (frame_done === 1'h1) dones++;
    if (frame_error === 1'h1) errs++;
  end

  // ==========================================================================
  // Checking
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'h1) begin
      fails++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic conclude();
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic run(input row_s r);
    logic [31:0] rd;
    logic [31:0] exp_rd;
    logic [39:0] wb;
    int          cnt;
    wb = {r.wd, r.wd[31:24]};
    exp_rd = 32'h0;
    cnt = (r.kind == blk_reserved) ? 0 : int'(r.n);
    @(posedge core_clk);
    #1 fixed_length_mode = r.fm;
    acc_q.delete();
    dones = 0;
    errs = 0;
    u_host.xfer(!r.fm, r.off, {r.bsb, r.rw, r.len}, r.n, r.wd, rd);
    repeat (4) @(posedge core_clk);
    #1;
    if (r.fm) chk(acc_q.size() == cnt, "access count");
    else chk(acc_q.size() >= cnt, "access count");
    chk(dones == int'(r.fm), "frame end pulse");
    chk(errs == int'(r.fm && r.len == 2'h0), "length error");
    foreach (acc_q[k]) begin
      chk(acc_q[k].offset === r.off + 16'(k), "offset");
      chk(acc_q[k].write === r.rw, "direction");
      chk(acc_q[k].blk.kind === r.kind, "block kind");
      chk(acc_q[k].blk.socket === r.sock, "socket");
      if (r.rw) chk(acc_q[k].wdata === wb[39 - 8 * k -: 8], "wdata");
    end
    if (!r.rw) begin
      for (int k = 0; k < r.n; k++)
        exp_rd = {exp_rd[23:0], r.off[7:0] + 8'(k) ^ 8'h5a};
      chk(rd === exp_rd, "read data");
    end
  endtask

  // ==========================================================================
  // Cases: fixed frames back to back, then select-framed ones
  row_s rows[10] = '{
    '{1'h1, 1'h1, 2'h1, 5'h00, 16'h0000, 32'haa000000, 3'h1, blk_common, 3'h0},
    '{1'h1, 1'h1, 2'h2, 5'h06, 16'hfffe, 32'h11220000, 3'h2, blk_sock_tx, 3'h1},
    '{1'h1, 1'h1, 2'h3, 5'h1d, 16'h0040, 32'h01020304, 3'h4, blk_sock_reg, 3'h7},
    '{1'h1, 1'h0, 2'h1, 5'h0f, 16'h0100, 32'h0, 3'h1, blk_sock_rx, 3'h3},
    '{1'h1, 1'h0, 2'h2, 5'h12, 16'h1234, 32'h0, 3'h2, blk_sock_tx, 3'h4},
    '{1'h1, 1'h0, 2'h3, 5'h1f, 16'hffff, 32'h0, 3'h4, blk_sock_rx, 3'h7},
    '{1'h1, 1'h1, 2'h3, 5'h08, 16'h0200, 32'hdeadbeef, 3'h4, blk_reserved, 3'h2},
    '{1'h1, 1'h1, 2'h0, 5'h0e, 16'h0300, 32'h5a000000, 3'h1, blk_sock_tx, 3'h3},
    '{1'h0, 1'h1, 2'h0, 5'h06, 16'h0040, 32'h11223344, 3'h5, blk_sock_tx, 3'h1},
    '{1'h0, 1'h0, 2'h0, 5'h1d, 16'h0003, 32'h0, 3'h2, blk_sock_reg, 3'h7}
  };

  initial begin
    logic [31:0] rd;
    repeat (5) @(posedge core_clk);
    #1 rstn = 1'h1;
    repeat (5) @(posedge core_clk);
    foreach (rows[i]) run(rows[i]);
    // Reset lands in a read data phase; the port must frame afresh
    @(posedge core_clk);
    #1 fixed_length_mode = 1'h1;
    fork
      u_host.xfer(1'h0, 16'h0010, 8'h0b, 4, 32'h0, rd);
      begin
        #2500 rstn = 1'h0;
        #20 chk(acc_valid === 1'h0 && miso_oe === 1'h0 && miso === 1'h0
                && frame_done === 1'h0 && frame_error === 1'h0
                && acc === '0, "reset values");
      end
    join
    @(posedge core_clk);
    #1 rstn = 1'h1;
    repeat (5) @(posedge core_clk);
    run(rows[2]);
    run(rows[5]);
    conclude();
  end

  initial begin
    #300us;
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
